// [logic/wheel_motion_command.sv]
// Purpose: front-panel wheel and menu move logic with display status line
// Assumes: servo loop raises motor_busy within one cycle of move_start
// Notes: registers over classic wishbone, one-cycle ack
// Notes on behaviour
// - wheel at centre commands no motion.
// - position mode: down goes to taught position one, up to two.
// - rotary go-to targets the angle inside the current full-turn segment.
// - jog mode: deflection starts a jog, repeats after each completes while held.
// - velocity mode speed steps with deflection, full deflection gives max velocity.
// - velocity direction follows the side of deflection.
// - velocity move stops when wheel returns to centre.
// - status line ends with mode letter V, P or J.
// - display shows position, moving or stopped, and homed once homed.
// - rotary display always shows single-turn non-negative angle.
// - total-angle setting changes only the host view, not the display.
// - homing counts down; completion shows position zero and homed.
// - menu press stops a menu-started go-to or homing move.
// - menu go-to target limited to travel, or one turn for rotary.
// - stored max velocity governs every later move.
// - stored jog step sets the distance of every later jog.
// - teach command stores current position into the chosen slot.
// - disable setting makes the wheel ignored.
//
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "wheel_defs.svh"

module wheel_motion_command
    import wheel_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [11:0] wheel_adc,
    input wire logic menu_btn,
    input wire logic signed [31:0] motor_pos,
    input wire logic motor_busy,
    input wire logic home_done,
    output move_cmd_t move_cmd,
    output logic move_start,
    output disp_line_t disp_line
);

    localparam int TB = `TURN_BITS;

    logic [31:0] ctrl_r;
    logic [31:0] max_vel_r;
    logic [31:0] jog_step_r;
    logic [31:0] travel_r;
    logic signed [31:0] goto_r;
    logic signed [31:0] taught_position_one;
    logic signed [31:0] taught_position_two;
    logic signed [31:0] host_pos_r;
    logic homed_r;
    logic seen_busy_r;
    logic btn_s1_r;
    logic btn_s2_r;
    logic btn_s3_r;
    motion_state_t state_r;
    logic [2:0] q_level;
    logic q_up;
    logic [2:0] defl;
    logic bus_hit;
    logic wr;
    logic cmd_wr;
    logic btn_press;
    logic move_done;
    logic rotary;
    wheel_mode_t mode;
    logic signed [31:0] single_turn;
    logic signed [31:0] seg_base;
    logic signed [31:0] goto_target;
    logic [31:0] wheel_vel;
    logic [31:0] rd_nxt;

    function automatic logic [31:0] apply_sel(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction : apply_sel

    function automatic logic signed [31:0] single_turn_of(input logic signed [31:0] p);
        return {{(32 - TB){1'b0}}, p[TB-1:0]};
    endfunction : single_turn_of

    wheel_quant u_quant (
        .sys_clk(sys_clk),
        .rst(rst),
        .wheel_adc(wheel_adc),
        .level(q_level),
        .up(q_up)
    );

    assign rotary = ctrl_r[`CTRL_ROT_BIT];
    assign mode = wheel_mode_t'(ctrl_r[`CTRL_MODE_LSB +: 2]);
    assign defl = ctrl_r[`CTRL_DIS_BIT] ? 3'h0 : q_level;
    assign bus_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = bus_hit & wb_we_i;
    assign cmd_wr = wr && (wb_adr_i == `REG_CMD);
    assign btn_press = btn_s2_r & ~btn_s3_r;
    assign move_done = seen_busy_r & ~motor_busy & ~move_start;
    // power-of-two turn: masking gives a floor modulo, also for negative counts
    assign single_turn = {{(32 - TB){1'b0}}, motor_pos[TB-1:0]};
    assign seg_base = {motor_pos[31:TB], {TB{1'b0}}};

    // clamp then place inside the current turn segment
    always_comb begin
        goto_target = goto_r;
        if (goto_r < 0) begin
            goto_target = 32'sh0;
        end else if (rotary && goto_r > $signed({{(32 - TB){1'b0}}, {TB{1'b1}}})) begin
            goto_target = $signed({{(32 - TB){1'b0}}, {TB{1'b1}}});
        end else if (!rotary && goto_r > $signed(travel_r)) begin
            goto_target = $signed(travel_r);
        end
        if (rotary) begin
            goto_target = seg_base + goto_target;
        end
    end

    // steps of one eighth of max; the top level takes max exactly
    always_comb begin
        if (defl == `LEVEL_FULL) begin
            wheel_vel = max_vel_r;
        end else begin
            wheel_vel = 32'((max_vel_r >> `VEL_STEP_SHIFT) * {29'h0, defl});
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            btn_s1_r <= 1'b0;
            btn_s2_r <= 1'b0;
            btn_s3_r <= 1'b0;
        end else begin
            btn_s1_r <= menu_btn;
            btn_s2_r <= btn_s1_r;
            btn_s3_r <= btn_s2_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_r <= `CTRL_RST;
            max_vel_r <= `MAX_VEL_RST;
            jog_step_r <= `JOG_STEP_RST;
            travel_r <= `TRAVEL_RST;
            goto_r <= 32'sh0;
        end else if (wr) begin
            case (wb_adr_i)
                `REG_CTRL: ctrl_r <= apply_sel(ctrl_r, wb_dat_i, wb_sel_i) & 32'h0000_001f;
                `REG_MAX_VEL: max_vel_r <= apply_sel(max_vel_r, wb_dat_i, wb_sel_i);
                `REG_JOG_STEP: jog_step_r <= apply_sel(jog_step_r, wb_dat_i, wb_sel_i);
                `REG_TRAVEL: travel_r <= apply_sel(travel_r, wb_dat_i, wb_sel_i);
                `REG_GOTO: goto_r <= $signed(apply_sel(goto_r, wb_dat_i, wb_sel_i));
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            taught_position_one <= 32'sh0;
            taught_position_two <= 32'sh0;
        end else if (cmd_wr) begin
            if (wb_dat_i[`CMD_TEACH1_BIT]) begin
                taught_position_one <= motor_pos;
            end
            if (wb_dat_i[`CMD_TEACH2_BIT]) begin
                taught_position_two <= motor_pos;
            end
        end
    end

    always_comb begin
        case (wb_adr_i)
            `REG_CTRL: rd_nxt = ctrl_r;
            `REG_MAX_VEL: rd_nxt = max_vel_r;
            `REG_JOG_STEP: rd_nxt = jog_step_r;
            `REG_TAUGHT_ONE: rd_nxt = taught_position_one;
            `REG_TAUGHT_TWO: rd_nxt = taught_position_two;
            `REG_GOTO: rd_nxt = goto_r;
            `REG_STATUS: rd_nxt = {21'h0, state_r, disp_line.letter};
            `REG_DISP_POS: rd_nxt = disp_line.pos;
            `REG_HOST_POS: rd_nxt = host_pos_r;
            `REG_TRAVEL: rd_nxt = travel_r;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_hit;
            wb_dat_o <= (bus_hit && !wb_we_i) ? rd_nxt : 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            seen_busy_r <= 1'b0;
        end else if (move_start) begin
            seen_busy_r <= 1'b0;
        end else if (motor_busy) begin
            seen_busy_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            move_start <= 1'b0;
            move_cmd <= '{kind: MV_NONE, dir: 1'b0, vel: 32'h0, target: 32'sh0};
        end else begin
            move_start <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (cmd_wr && wb_dat_i[`CMD_GOTO_BIT]) begin
                        move_start <= 1'b1;
                        move_cmd <= '{kind: MV_ABS, dir: 1'b0, vel: max_vel_r, target: goto_target};
                        state_r <= ST_MENU;
                    end else if (cmd_wr && wb_dat_i[`CMD_HOME_BIT]) begin
                        move_start <= 1'b1;
                        move_cmd <= '{kind: MV_HOME, dir: 1'b0, vel: max_vel_r, target: 32'sh0};
                        state_r <= ST_MENU;
                    end else if (defl != 3'h0 && !motor_busy) begin
                        move_start <= 1'b1;
                        case (mode)
                            WM_POSITION: begin
                                move_cmd.kind <= MV_ABS;
                                move_cmd.dir <= q_up;
                                move_cmd.vel <= max_vel_r;
                                if (q_up) begin
                                    move_cmd.target <= rotary ? seg_base + single_turn_of(taught_position_two)
                                                              : taught_position_two;
                                end else begin
                                    move_cmd.target <= rotary ? seg_base + single_turn_of(taught_position_one)
                                                              : taught_position_one;
                                end
                                state_r <= ST_POS;
                            end
                            WM_JOG: begin
                                move_cmd <= '{kind: MV_REL, dir: q_up, vel: max_vel_r,
                                              target: q_up ? $signed(jog_step_r) : -$signed(jog_step_r)};
                                state_r <= ST_JOG;
                            end
                            default: begin
                                move_cmd <= '{kind: MV_VEL, dir: q_up, vel: wheel_vel, target: 32'sh0};
                                state_r <= ST_VEL;
                            end
                        endcase
                    end
                end
                ST_VEL: begin
                    if (defl == 3'h0) begin
                        move_start <= 1'b1;
                        move_cmd.kind <= MV_STOP;
                        state_r <= ST_IDLE;
                    end else if (wheel_vel != move_cmd.vel || q_up != move_cmd.dir) begin
                        move_start <= 1'b1;
                        move_cmd.vel <= wheel_vel;
                        move_cmd.dir <= q_up;
                    end
                end
                ST_JOG: begin
                    if (move_done) begin
                        if (defl != 3'h0) begin
                            move_start <= 1'b1;
                            move_cmd <= '{kind: MV_REL, dir: q_up, vel: max_vel_r,
                                          target: q_up ? $signed(jog_step_r) : -$signed(jog_step_r)};
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_POS: begin
                    if (move_done) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_MENU: begin
                    if (btn_press || (cmd_wr && wb_dat_i[`CMD_STOP_BIT])) begin
                        move_start <= 1'b1;
                        move_cmd.kind <= MV_STOP;
                        state_r <= ST_IDLE;
                    end else if (move_done) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            homed_r <= 1'b0;
        end else if (home_done) begin
            homed_r <= 1'b1;
        end
    end

    // homing count-down is the servo's live position passing through
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            disp_line <= '{pos: 32'sh0, moving: 1'b0, homed: 1'b0, letter: `LETTER_V};
            host_pos_r <= 32'sh0;
        end else begin
            if (home_done) begin
                disp_line.pos <= 32'sh0;
            end else begin
                disp_line.pos <= rotary ? single_turn : motor_pos;
            end
            disp_line.moving <= motor_busy;
            disp_line.homed <= homed_r | home_done;
            case (mode)
                WM_POSITION: disp_line.letter <= `LETTER_P;
                WM_JOG: disp_line.letter <= `LETTER_J;
                default: disp_line.letter <= `LETTER_V;
            endcase
            host_pos_r <= (rotary && !ctrl_r[`CTRL_TOTAL_BIT]) ? single_turn : motor_pos;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_jog_held_done;
        state_r == ST_JOG && move_done && defl != 3'h0;
    endsequence

    sequence s_jog_restart;
        move_start && move_cmd.kind == MV_REL && move_cmd.vel == $past(max_vel_r);
    endsequence

    chk_centre_no_move: assert property ((state_r == ST_IDLE && defl == 3'h0 && !cmd_wr) |=> !move_start)
        else $error("move started with wheel centred");
    chk_goto_slot: assert property ((state_r == ST_IDLE && mode == WM_POSITION && defl != 3'h0 && !motor_busy
        && !cmd_wr && !rotary) |=> move_start && move_cmd.target == ($past(q_up) ? taught_position_two
        : taught_position_one))
        else $error("wrong taught position target");
    chk_turn_segment: assert property ((move_start && move_cmd.kind == MV_ABS && rotary)
        |-> move_cmd.target[31:TB] == $past(motor_pos[31:TB]))
        else $error("go-to left the current turn segment");
    chk_jog_repeat: assert property (s_jog_held_done |=> s_jog_restart)
        else $error("jog not repeated");
    chk_full_speed: assert property ((move_start && move_cmd.kind == MV_VEL && $past(defl) == `LEVEL_FULL)
        |-> move_cmd.vel == $past(max_vel_r))
        else $error("full deflection not at max velocity");
    chk_vel_dir: assert property ((move_start && move_cmd.kind == MV_VEL) |-> move_cmd.dir == $past(q_up))
        else $error("velocity direction wrong");
    chk_vel_stop: assert property ((state_r == ST_VEL && defl == 3'h0)
        |=> move_start && move_cmd.kind == MV_STOP ##1 state_r == ST_IDLE && !move_start)
        else $error("velocity move not stopped");
    chk_mode_letter: assert property ($past(mode) == WM_JOG |-> disp_line.letter == `LETTER_J)
        else $error("mode letter wrong");
    chk_home_zero: assert property (home_done |=> disp_line.homed && disp_line.pos == 32'sh0)
        else $error("homing end not shown");
    chk_menu_stop: assert property ((state_r == ST_MENU && btn_press)
        |=> move_start && move_cmd.kind == MV_STOP && state_r == ST_IDLE)
        else $error("menu press did not stop move");
    chk_goto_clamp: assert property ((move_start && move_cmd.kind == MV_ABS && $past(state_r) == ST_IDLE
        && !rotary && $past(cmd_wr)) |-> move_cmd.target >= 0 && move_cmd.target <= $signed(travel_r))
        else $error("go-to target out of travel");
    chk_busy_hold: assert property ((state_r == ST_POS && motor_busy) |=> !move_start)
        else $error("new move during position move");

endmodule : wheel_motion_command

// [logic/wheel_quant.sv]
// Purpose: synchronise and quantise the wheel potentiometer reading
// Assumes: wheel_adc arrives from outside the clock domain
// Notes: level 0 means centred; full deflection gives the top level
`timescale 1ns/1ps
`include "wheel_defs.svh"

module wheel_quant
    import wheel_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [11:0] wheel_adc,
    output logic [2:0] level,
    output logic up
);

    logic [11:0] adc_s1_r;
    logic [11:0] adc_s2_r;
    logic [11:0] mag;
    logic [11:0] over;
    logic [11:0] lvl_wide;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            adc_s1_r <= 12'h800;
            adc_s2_r <= 12'h800;
        end else begin
            adc_s1_r <= wheel_adc;
            adc_s2_r <= adc_s1_r;
        end
    end

    // bits of a multi-bit reading may skew; a slow pot makes that harmless
    always_comb begin
        if (adc_s2_r >= `WHEEL_CENTRE) begin
            mag = adc_s2_r - `WHEEL_CENTRE;
        end else begin
            mag = `WHEEL_CENTRE - adc_s2_r;
        end
        if (mag > `WHEEL_MAG_MAX) begin
            mag = `WHEEL_MAG_MAX;
        end
        over = (mag >= `WHEEL_DEAD) ? (mag - `WHEEL_DEAD) : 12'h000;
        lvl_wide = (over >> `LEVEL_SHIFT) + 12'h001;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            level <= 3'h0;
            up <= 1'b0;
        end else begin
            up <= (adc_s2_r >= `WHEEL_CENTRE);
            if (mag < `WHEEL_DEAD) begin
                level <= 3'h0;
            end else if (lvl_wide > 12'h007) begin
                level <= `LEVEL_FULL;
            end else begin
                level <= lvl_wide[2:0];
            end
        end
    end

endmodule : wheel_quant

// [shared/wheel_defs.svh]
// Purpose: offsets, field positions, reset values and wheel constants
// Assumes: 32-bit classic wishbone, byte address on wb_adr_i[7:0]
// Notes: turn size is a power of two so segment math stays a bit-select
`ifndef WHEEL_DEFS_SVH
`define WHEEL_DEFS_SVH

`define REG_CTRL 8'h00
`define REG_MAX_VEL 8'h04
`define REG_JOG_STEP 8'h08
`define REG_TAUGHT_ONE 8'h0c
`define REG_TAUGHT_TWO 8'h10
`define REG_GOTO 8'h14
`define REG_CMD 8'h18
`define REG_STATUS 8'h1c
`define REG_DISP_POS 8'h20
`define REG_HOST_POS 8'h24
`define REG_TRAVEL 8'h28

`define CTRL_MODE_LSB 0
`define CTRL_DIS_BIT 2
`define CTRL_TOTAL_BIT 3
`define CTRL_ROT_BIT 4

`define CMD_GOTO_BIT 0
`define CMD_HOME_BIT 1
`define CMD_TEACH1_BIT 2
`define CMD_TEACH2_BIT 3
`define CMD_STOP_BIT 4

`define CTRL_RST 32'h0000_0000
`define MAX_VEL_RST 32'h0000_1000
`define JOG_STEP_RST 32'h0000_0100
`define TRAVEL_RST 32'h0001_0000

`define WHEEL_CENTRE 12'h800
`define WHEEL_MAG_MAX 12'h7ff
`define WHEEL_DEAD 12'h040
`define LEVEL_SHIFT 8
`define LEVEL_FULL 3'h7
`define VEL_STEP_SHIFT 3

`define TURN_BITS 16

`define LETTER_V 8'h56
`define LETTER_P 8'h50
`define LETTER_J 8'h4a

`endif

// [shared/wheel_pkg.sv]
// Purpose: types shared by the wheel motion logic
// Assumes: nothing beyond the defs header
// Notes: move_cmd_t is the carrier toward the servo loop
package wheel_pkg;

    typedef enum logic [1:0] {WM_VELOCITY, WM_POSITION, WM_JOG, WM_SPARE} wheel_mode_t;

    typedef enum logic [2:0] {MV_NONE, MV_VEL, MV_REL, MV_ABS, MV_HOME, MV_STOP} move_kind_t;

    typedef enum logic [2:0] {ST_IDLE, ST_VEL, ST_JOG, ST_POS, ST_MENU} motion_state_t;

    typedef struct packed {
        move_kind_t kind;
        logic dir;
        logic [31:0] vel;
        logic signed [31:0] target;
    } move_cmd_t;

    typedef struct packed {
        logic signed [31:0] pos;
        logic moving;
        logic homed;
        logic [7:0] letter;
    } disp_line_t;

endpackage : wheel_pkg

// [testbench/stage_model.sv]
// Purpose: servo loop and stage stand-in behind move_cmd
// Assumes: busy rises the cycle after move_start
// Notes: homing counts down, then lands at zero
`timescale 1ns/1ps
module stage_model
    import wheel_pkg::*;
#(parameter int MOVE_CYC = 40)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire move_cmd_t move_cmd,
    input wire logic move_start,
    output logic signed [31:0] motor_pos,
    output logic motor_busy,
    output logic home_done
);
    logic signed [31:0] goal_r;
    int cnt_r;
    logic homing_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            {motor_pos, motor_busy, home_done, goal_r, cnt_r, homing_r} <= '0;
        end else if (move_start) begin
            motor_busy <= move_cmd.kind != MV_STOP;
            // velocity moves run until a stop arrives
            cnt_r <= (move_cmd.kind == MV_VEL || move_cmd.kind == MV_STOP) ? 0 : MOVE_CYC;
            homing_r <= move_cmd.kind == MV_HOME;
            goal_r <= (move_cmd.kind == MV_REL) ? motor_pos + move_cmd.target :
                      (move_cmd.kind == MV_HOME) ? 32'sh0 : move_cmd.target;
            home_done <= 1'b0;
        end else begin
            home_done <= homing_r && cnt_r == 1;
            if (cnt_r == 1) begin
                motor_busy <= 1'b0;
                motor_pos <= goal_r;
            end else if (homing_r && cnt_r > 1) begin
                motor_pos <= motor_pos - 1;
            end
            if (cnt_r > 0) begin
                cnt_r <= cnt_r - 1;
            end
        end
    end
endmodule : stage_model

// [testbench/wheel_motion_command_test.sv]
// Purpose: self-checking bench for the wheel motion logic
// Assumes: stage stand-in answers every move, menu button driven here
// Notes: random wheel deflections from a fixed seed
`timescale 1ns/1ps
`include "wheel_defs.svh"
module wheel_motion_command_test
    import wheel_pkg::*;
;
    logic sys_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, btn = 0, ack, busy, hdone, mstart, up;
    logic [7:0] adr = 0;
    logic [3:0] sel = 0;
    logic [31:0] wdat = 0, rdat, q, mx, stp, t1, t2;
    logic [11:0] adc = 12'h800, m;
    logic signed [31:0] pos;
    move_cmd_t cmd, last;
    disp_line_t disp;
    int mismatches = 0, tests_run = 0, starts = 0, st;
    always #4 sys_clk = ~sys_clk;
    wheel_motion_command dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wheel_adc(adc),
        .menu_btn(btn), .motor_pos(pos), .motor_busy(busy), .home_done(hdone), .move_cmd(cmd),
        .move_start(mstart), .disp_line(disp));
    stage_model #(.MOVE_CYC(40)) model (.sys_clk(sys_clk), .rst(rst), .move_cmd(cmd), .move_start(mstart),
        .motor_pos(pos), .motor_busy(busy), .home_done(hdone));
    always @(posedge sys_clk) begin
        if (mstart === 1'b1) begin
            last <= cmd;
            starts <= starts + 1;
        end
    end
    function automatic logic [31:0] ev(input logic [11:0] mg, input logic [31:0] mxv);
        logic [3:0] lvl;
        lvl = 4'((mg - 12'h40) >> 8) + 4'h1;
        return (lvl >= 4'h7) ? mxv : (mxv >> 3) * lvl;
    endfunction : ev
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {cyc, stb, we, sel} <= {1'b1, 1'b1, w, 4'hf};
        adr <= a;
        wdat <= d;
        // no local limit: only the watchdog ends a wait for ack
        do begin
            @(posedge sys_clk);
        end while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask : wb
    task automatic wstart();
        int n, s0;
        s0 = starts;
        n = 0;
        while (starts == s0 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        chk(32'(starts != s0), 32'h1);
    endtask : wstart
    task automatic wh(input logic [11:0] v);
        @(posedge sys_clk);
        adc <= v;
    endtask : wh
    task automatic idle();
        repeat (3) @(posedge sys_clk);
        while (busy !== 1'b0) begin
            @(posedge sys_clk);
        end
        repeat (3) @(posedge sys_clk);
    endtask : idle
    task automatic end_of_test();
        if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        // long enough for every move, short of a real hang
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'hd299));
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        wb(0, `REG_MAX_VEL, 0);
        chk(q, `MAX_VEL_RST);
        wb(0, `REG_TRAVEL, 0);
        chk(q, `TRAVEL_RST);
        wb(0, 8'hfc, 0);
        chk(q, 32'h0);
        chk(disp.letter, `LETTER_V);
        chk(starts, 0);
        mx = $urandom & 32'h00ff_fff8;
        wb(1, `REG_MAX_VEL, mx);
        for (int i = 0; i < 6; i++) begin
            m = (i == 0) ? 12'h7ff : 12'h48 + 12'($urandom_range(0, 32'h7b7));
            up = (i == 0) ? 1'b1 : 1'($urandom);
            wh(up ? 12'h800 + m : 12'h800 - m);
            wstart();
            chk(last.kind, MV_VEL);
            chk(last.dir, up);
            chk(last.vel, ev(m, mx));
            wh(`WHEEL_CENTRE);
            wstart();
            chk(last.kind, MV_STOP);
        end
        idle();
        st = starts;
        wh(12'h83f);
        repeat (20) @(posedge sys_clk);
        chk(starts, st);
        wb(1, `REG_CTRL, 32'h4);
        st = starts;
        wh(12'hfff);
        repeat (20) @(posedge sys_clk);
        chk(starts, st);
        wh(`WHEEL_CENTRE);
        repeat (5) @(posedge sys_clk);
        stp = 32'h40 + ($urandom & 32'hff);
        wb(1, `REG_JOG_STEP, stp);
        wb(1, `REG_CTRL, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk(disp.letter, `LETTER_J);
        wh(12'hc00);
        wstart();
        chk(last.kind, MV_REL);
        chk(last.target, stp);
        chk(last.vel, mx);
        wstart();
        chk(last.target, stp);
        wh(`WHEEL_CENTRE);
        idle();
        wb(1, `REG_CMD, 32'h4);
        wb(0, `REG_TAUGHT_ONE, 0);
        chk(q, pos);
        t1 = q;
        wh(12'h400);
        wstart();
        chk(last.target, -stp);
        wh(`WHEEL_CENTRE);
        idle();
        wb(1, `REG_CMD, 32'h8);
        wb(0, `REG_TAUGHT_TWO, 0);
        chk(q, pos);
        t2 = q;
        wb(1, `REG_CTRL, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk(disp.letter, `LETTER_P);
        for (int i = 0; i < 2; i++) begin
            wh(i == 0 ? 12'h000 : 12'hfff);
            wstart();
            chk(last.kind, MV_ABS);
            chk(last.target, i == 0 ? t1 : t2);
            wh(`WHEEL_CENTRE);
            idle();
        end
        wb(1, `REG_CTRL, 32'h0);
        wb(1, `REG_GOTO, 32'h7fff_0000);
        wb(1, `REG_CMD, 32'h1);
        wstart();
        chk(last.target, `TRAVEL_RST);
        wb(1, `REG_CMD, 32'h10);
        wstart();
        chk(last.kind, MV_STOP);
        idle();
        wb(1, `REG_CMD, 32'h1);
        wstart();
        btn <= 1'b1;
        wstart();
        chk(last.kind, MV_STOP);
        btn <= 1'b0;
        idle();
        t1 = 32'h0003_0000 | ($urandom & 32'hffff);
        t2 = $urandom & 32'hffff;
        wb(1, `REG_TRAVEL, 32'h0004_0000);
        wb(1, `REG_GOTO, t1);
        wb(1, `REG_CMD, 32'h1);
        wstart();
        chk(last.target, t1);
        idle();
        wb(1, `REG_CTRL, 32'h13);
        wb(0, `REG_HOST_POS, 0);
        chk(q, {16'h0, t1[15:0]});
        chk(disp.pos, {16'h0, t1[15:0]});
        chk(disp.letter, `LETTER_V);
        wb(1, `REG_CTRL, 32'h1b);
        wb(0, `REG_HOST_POS, 0);
        chk(q, t1);
        chk(disp.pos, {16'h0, t1[15:0]});
        wb(1, `REG_GOTO, t2);
        wb(1, `REG_CMD, 32'h1);
        wstart();
        chk(last.target, {t1[31:16], t2[15:0]});
        idle();
        wb(1, `REG_CMD, 32'h2);
        wstart();
        chk(last.kind, MV_HOME);
        repeat (3) @(posedge sys_clk);
        chk(disp.moving, 1'b1);
        chk(disp.homed, 1'b0);
        idle();
        chk(disp.pos, 32'h0);
        chk(disp.homed, 1'b1);
        chk(disp.moving, 1'b0);
        end_of_test();
    end
endmodule : wheel_motion_command_test
